// [hw/tao_delay.sv]
`timescale 1ns/100ps
module tao_delay #(
  parameter int DELAY_CYCLES = tao_pkg::POWERUP_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      done
);

  typedef struct packed {
    logic [tao_pkg::CNT_W-1:0] cnt;
    logic                      done;
  } tao_dly_s;

  tao_dly_s st_ff;
  tao_dly_s nxt_st;

  localparam int                        LAST_I = DELAY_CYCLES - 1;
  localparam logic [tao_pkg::CNT_W-1:0] LAST   = LAST_I[tao_pkg::CNT_W-1:0];

  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.done) begin
      if (st_ff.cnt == LAST) begin
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

  a_done_sticky: assert property (@(posedge core_clk) disable iff (rst)
    done |=> done) else $error("delay done dropped");

endmodule // tao_delay

// [hw/tao_pkg.sv]
// Functional notes
// - Alarm asserts whenever a fault occurred and the drive is in trip.
// - Alarm holds until fault clear, then stays off until a new alarm.
// - Output option code 05 routes the alarm to open-collector or relay.
// - After configuration reset the alarm goes to the relay output.
// - Polarity defaults to normally closed: coil energized without alarm.
// - Normally closed: coil energizes after power-up plus a delay under 2 s.
// - Normally closed: trip de-energizes the coil; power loss also drops it.
// - Normally open: coil energized only while a trip alarm is active.
package tao_pkg;

  // ----------------------------------------------------------------------
  // Option codes and defaults
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPT_ALARM       = 8'h05;
  localparam logic       POL_NC          = 1'b1;
  localparam logic       POL_NO          = 1'b0;
  localparam logic [7:0] RESET_OC_OPT    = 8'h00;
  localparam logic [7:0] RESET_RELAY_OPT = OPT_ALARM;
  localparam logic       RESET_POLARITY  = POL_NC;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int POWERUP_MS     = 300;
  localparam int POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_MS;
  localparam int CNT_W          = 24;

endpackage

// [hw/tao_top.sv]
`timescale 1ns/100ps
module tao_top #(
  parameter int POWERUP_CYCLES = tao_pkg::POWERUP_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       fault_trip,
  input  wire logic       fault_clear,
  input  wire logic       cfg_load,
  input  wire logic [7:0] cfg_oc_option,
  input  wire logic [7:0] cfg_relay_option,
  input  wire logic       cfg_relay_polarity,
  output logic            trip_alarm_function,
  output logic            oc_output_drive,
  output logic            relay_coil_drive
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       alarm;
    logic [7:0] oc_opt;
    logic [7:0] relay_opt;
    logic       pol;
    logic       oc_q;
    logic       coil_q;
  } tao_state_s;

  tao_state_s st_ff;
  tao_state_s nxt_st;
  logic       pwr_ok;

  // ----------------------------------------------------------------------
  // Power-up delay
  // ----------------------------------------------------------------------
  // Held low from reset until a normally closed relay may first be energized
  tao_delay #(
    .DELAY_CYCLES (POWERUP_CYCLES)
  ) u_delay (
    .core_clk (core_clk),
    .rst      (rst),
    .done     (pwr_ok)
  );

  // ----------------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------------
  // An output carries the alarm only when its option selects the alarm
  function automatic logic routed(input logic [7:0] opt, input logic a);
    routed = (opt == tao_pkg::OPT_ALARM) && a;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic alarm_n;
    logic relay_fn;
    alarm_n  = st_ff.alarm;
    relay_fn = 1'b0;
    nxt_st   = st_ff;
    // Trip wins over a simultaneous clear
    if (fault_trip) begin
      alarm_n = 1'b1;
    end else if (fault_clear) begin
      alarm_n = 1'b0;
    end
    nxt_st.alarm = alarm_n;
    if (cfg_load) begin
      nxt_st.oc_opt    = cfg_oc_option;
      nxt_st.relay_opt = cfg_relay_option;
      nxt_st.pol       = cfg_relay_polarity;
    end
    // Drives use the new alarm, so they change in the same cycle as it
    nxt_st.oc_q = routed(st_ff.oc_opt, alarm_n);
    relay_fn    = routed(st_ff.relay_opt, alarm_n);
    if (st_ff.pol == tao_pkg::POL_NC) begin
      nxt_st.coil_q = pwr_ok && !relay_fn;
    end else begin
      nxt_st.coil_q = relay_fn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff.alarm     <= 1'b0;
      st_ff.oc_opt    <= tao_pkg::RESET_OC_OPT;
      st_ff.relay_opt <= tao_pkg::RESET_RELAY_OPT;
      st_ff.pol       <= tao_pkg::RESET_POLARITY;
      st_ff.oc_q      <= 1'b0;
      st_ff.coil_q    <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign trip_alarm_function = st_ff.alarm;
  assign oc_output_drive     = st_ff.oc_q;
  assign relay_coil_drive    = st_ff.coil_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb_chk @(posedge core_clk);
  endclocking

  default disable iff (rst);

  a_trip_sets: assert property (
    fault_trip |=> trip_alarm_function
  ) else $error("trip did not raise alarm");

  a_alarm_cause: assert property (
    $rose(trip_alarm_function) |-> $past(fault_trip)
  ) else $error("alarm rose without trip");

  a_clear_drops: assert property (
    fault_clear && !fault_trip |=> !trip_alarm_function
  ) else $error("clear did not drop alarm");

  a_alarm_holds: assert property (
    !fault_clear && !fault_trip |=> $stable(trip_alarm_function)
  ) else $error("alarm changed without cause");

  // Config lands one cycle after its load and reaches the drives a cycle
  // later, so drive checks skip the cycle right after a load, and the follow checks also the one after a reset
  a_oc_route: assert property (
    oc_output_drive |-> trip_alarm_function
  ) else $error("oc output active without alarm");

  a_oc_follow: assert property (
    !$past(rst) && !$past(cfg_load)
    |-> oc_output_drive
        == (st_ff.oc_opt == tao_pkg::OPT_ALARM && trip_alarm_function)
  ) else $error("oc output does not follow alarm");

  a_reset_relay: assert property (
    $fell(rst) |-> st_ff.relay_opt == tao_pkg::OPT_ALARM
  ) else $error("relay not routed at reset");

  a_reset_nc: assert property (
    $fell(rst) |-> st_ff.pol == tao_pkg::POL_NC
  ) else $error("polarity not nc at reset");

  a_reset_quiet: assert property (
    $fell(rst)
    |-> !relay_coil_drive && !oc_output_drive && !trip_alarm_function
  ) else $error("outputs active after reset");

  a_nc_wait: assert property (
    st_ff.pol == tao_pkg::POL_NC && !pwr_ok |=> !relay_coil_drive
  ) else $error("coil energized before delay");

  a_nc_trip: assert property (
    st_ff.pol == tao_pkg::POL_NC && st_ff.relay_opt == tao_pkg::OPT_ALARM
    && !$past(cfg_load) && trip_alarm_function
    |-> !relay_coil_drive
  ) else $error("nc coil held during alarm");

  a_nc_drop: assert property (
    st_ff.pol == tao_pkg::POL_NC && !$past(cfg_load) && !$past(rst)
    && $past(pwr_ok) && $fell(relay_coil_drive)
    |-> trip_alarm_function
  ) else $error("nc coil dropped without alarm");

  a_no_coil: assert property (
    st_ff.pol == tao_pkg::POL_NO && !$past(cfg_load) && relay_coil_drive
    |-> trip_alarm_function
  ) else $error("no coil without alarm");

  a_no_follow: assert property (
    st_ff.pol == tao_pkg::POL_NO && st_ff.relay_opt == tao_pkg::OPT_ALARM
    && !$past(cfg_load) && !$past(rst)
    |-> relay_coil_drive == trip_alarm_function
  ) else $error("no coil does not follow alarm");

  a_nc_idle: assert property (
    st_ff.pol == tao_pkg::POL_NC && pwr_ok
    && st_ff.relay_opt == tao_pkg::OPT_ALARM
    && !trip_alarm_function && !fault_trip && !cfg_load
    |=> relay_coil_drive
  ) else $error("nc coil not energized when idle");

  // ----------------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------------
  c_trip: cover property (
    fault_trip ##1 trip_alarm_function);
  c_clear: cover property (
    trip_alarm_function ##1 !trip_alarm_function);
  c_coil_on: cover property (
    $rose(relay_coil_drive));
  c_no_mode: cover property (
    st_ff.pol == tao_pkg::POL_NO && relay_coil_drive);
  c_oc_alarm: cover property (
    oc_output_drive);

endmodule // tao_top

// [test/tao_alarm_circuit.sv]
`timescale 1ns/100ps
// With wiring_nc set, a closed loop means no alarm, so a broken wire also reads as alarm
module tao_alarm_circuit (
  input  wire logic wiring_nc,
  input  wire logic relay_coil_drive,
  output logic      alarm_seen
);
  assign alarm_seen = wiring_nc ? !relay_coil_drive : relay_coil_drive;
endmodule // tao_alarm_circuit

// [test/trip_alarm_output_logic_tb_top.sv]
`timescale 1ns/100ps
module trip_alarm_output_logic_tb_top;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       fault_trip = 1'b0;
  logic       fault_clear = 1'b0;
  logic       cfg_load = 1'b0;
  logic [7:0] cfg_oc_option = 8'h00;
  logic [7:0] cfg_relay_option = 8'h05;
  logic       cfg_relay_polarity = 1'b1;
  logic       wiring_nc = 1'b1;
  logic       trip_alarm_function;
  logic       oc_output_drive;
  logic       relay_coil_drive;
  logic       alarm_seen;
  int         num_errors = 0;
  int         num_checks = 0;

  localparam int PWR_CYC = 10;

  always #10 core_clk = ~core_clk;

  tao_top #(.POWERUP_CYCLES(PWR_CYC)) i_tao_top (
    .core_clk(core_clk), .rst(rst), .fault_trip(fault_trip),
    .fault_clear(fault_clear), .cfg_load(cfg_load),
    .cfg_oc_option(cfg_oc_option), .cfg_relay_option(cfg_relay_option),
    .cfg_relay_polarity(cfg_relay_polarity),
    .trip_alarm_function(trip_alarm_function),
    .oc_output_drive(oc_output_drive), .relay_coil_drive(relay_coil_drive)
  );

  tao_alarm_circuit i_tao_alarm_circuit (
    .wiring_nc(wiring_nc), .relay_coil_drive(relay_coil_drive),
    .alarm_seen(alarm_seen)
  );

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(string name, logic seen, logic exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic outs(logic a, logic oc, logic coil);
    chk("alarm", trip_alarm_function, a);
    chk("oc_drive", oc_output_drive, oc);
    chk("coil", relay_coil_drive, coil);
  endtask

  task automatic trip(logic clr);
    fault_trip = 1'b1;
    fault_clear = clr;
    step(1);
    fault_trip = 1'b0;
    fault_clear = 1'b0;
  endtask

  task automatic clear();
    fault_clear = 1'b1;
    step(1);
    fault_clear = 1'b0;
  endtask

  task automatic load(logic [7:0] oc, logic [7:0] rl, logic pol);
    cfg_oc_option = oc;
    cfg_relay_option = rl;
    cfg_relay_polarity = pol;
    cfg_load = 1'b1;
    step(1);
    cfg_load = 1'b0;
    step(2);
  endtask

  // Coil held off through the power-up delay, then energized
  task automatic powerup();
    rst = 1'b0;
    step(1);
    outs(1'b0, 1'b0, 1'b0);
    step(PWR_CYC - 1);
    chk("coil_early", relay_coil_drive, 1'b0);
    step(1);
    outs(1'b0, 1'b0, 1'b1);
    chk("circuit", alarm_seen, 1'b0);
  endtask

  task automatic trip_nc();
    trip(1'b0);
    outs(1'b1, 1'b0, 1'b0);
    chk("circuit", alarm_seen, 1'b1);
    step(3);
    outs(1'b1, 1'b0, 1'b0);
    clear();
    outs(1'b0, 1'b0, 1'b1);
    step(1);
    outs(1'b0, 1'b0, 1'b1);
    trip(1'b1);
    outs(1'b1, 1'b0, 1'b0);
    clear();
  endtask

  task automatic routing();
    load(8'h05, 8'h00, 1'b1);
    trip(1'b0);
    outs(1'b1, 1'b1, 1'b1);
    clear();
    outs(1'b0, 1'b0, 1'b1);
    load(8'h00, 8'h05, 1'b0);
    wiring_nc = 1'b0;
    outs(1'b0, 1'b0, 1'b0);
    trip(1'b0);
    outs(1'b1, 1'b0, 1'b1);
    chk("circuit", alarm_seen, 1'b1);
    clear();
    outs(1'b0, 1'b0, 1'b0);
  endtask

  // Mid-run reset restores the polarity left at normally open by routing
  task automatic reset_again();
    rst = 1'b1;
    wiring_nc = 1'b1;
    step(2);
    powerup();
    trip(1'b0);
    outs(1'b1, 1'b0, 1'b0);
    chk("circuit", alarm_seen, 1'b1);
    clear();
    outs(1'b0, 1'b0, 1'b1);
  endtask

  task automatic complete_run();
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    complete_run();
  end

  initial begin
    step(12);
    powerup();
    trip_nc();
    routing();
    reset_again();
    complete_run();
  end
endmodule // trip_alarm_output_logic_tb_top
